// ---- design/lpf_pkg.sv ----
package lpf_pkg;
   // ****************************************
   // bus and map
   // ****************************************
   localparam int AXI_AW = 12;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [11:0] ADDR_STATUS = 12'h000;
   localparam logic [11:0] ADDR_FRAMES = 12'h004;
   localparam logic [11:0] ADDR_ENTRY_BASE = 12'h010;
   localparam int ENTRY_STRIDE_SHIFT = 4;
   localparam logic [1:0] WORD_CTRL = 2'h0;
   localparam logic [1:0] WORD_FLAGS = 2'h1;
   localparam logic [1:0] WORD_SRC = 2'h2;
   localparam logic [1:0] WORD_DST = 2'h3;

   // ****************************************
   // entry field layout
   // ****************************************
   localparam int CTRL_W = 7;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_PROTO_LSB = 1;
   localparam int CTRL_SRC_LSB = 3;
   localparam int CTRL_DST_LSB = 5;
   localparam int FLAGS_W = 10;
   localparam int FLAG_CRIT_W = 2;
   localparam int NUM_FLAGS = 5;
   localparam int PORT_W = 16;
   localparam int BOUND_HI_LSB = 16;

   localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
   localparam logic [FLAGS_W-1:0] FLAGS_RESET = 10'h2aa;
   localparam logic [31:0] PORT_RESET = 32'hffff0000;

   // ****************************************
   // encodings
   // ****************************************
   localparam logic [1:0] PROTO_ANY = 2'h0;
   localparam logic [1:0] PROTO_TCP = 2'h1;
   localparam logic [1:0] PROTO_UDP = 2'h2;
   localparam logic [1:0] PMODE_ANY = 2'h0;
   localparam logic [1:0] PMODE_EXACT = 2'h1;
   localparam logic [1:0] PMODE_RANGE = 2'h2;
   localparam logic [1:0] FCRIT_CLEAR = 2'h0;
   localparam logic [1:0] FCRIT_SET = 2'h1;
   localparam logic [1:0] FCRIT_ANY = 2'h2;
   localparam logic [7:0] IPPROTO_TCP = 8'h06;
   localparam logic [7:0] IPPROTO_UDP = 8'h11;

   // tcp header flag bits as on the wire
   localparam int TFLAG_W = 6;
   localparam int TFLAG_FIN = 0;
   localparam int TFLAG_SYN = 1;
   localparam int TFLAG_PSH = 3;
   localparam int TFLAG_ACK = 4;
   localparam int TFLAG_URG = 5;
endpackage

// ---- design/lpf_port_match.sv ----
module lpf_port_match
   import lpf_pkg::*;
(
   // criterion
   input wire logic [1:0] mode,
   input wire logic [PORT_W-1:0] low_val,
   input wire logic [PORT_W-1:0] high_val,
   // frame
   input wire logic [PORT_W-1:0] port,
   // result
   output logic hit
);
   wire logic exact_ok = (port == low_val);
   // both bounds inclusive; low above high never hits
   wire logic range_ok = (port >= low_val) && (port <= high_val);

   assign hit = (mode == PMODE_ANY) ? 1'b1 :
                (mode == PMODE_EXACT) ? exact_ok :
                (mode == PMODE_RANGE) ? range_ok : 1'b0;
endmodule

// ---- design/lpf_flag_match.sv ----
module lpf_flag_match
   import lpf_pkg::*;
(
   // criteria, two bits per flag: fin syn psh ack urg
   input wire logic [FLAGS_W-1:0] crit,
   // frame flags in the same order
   input wire logic [NUM_FLAGS-1:0] flags,
   // result
   output logic hit
);
   logic [NUM_FLAGS-1:0] ok;

   always_comb begin
      for (int i = 0; i < NUM_FLAGS; i++) begin
         unique case (crit[i*FLAG_CRIT_W +: FLAG_CRIT_W])
            FCRIT_CLEAR: ok[i] = !flags[i];
            FCRIT_SET: ok[i] = flags[i];
            FCRIT_ANY: ok[i] = 1'b1;
            default: ok[i] = 1'b0;
         endcase
      end
   end

   assign hit = &ok;
endmodule

// ---- design/lpf_matcher.sv ----
// Functional notes
// - tcp flags and ports only for tcp entries
// - udp ports only for udp entries
// - source don't-care ignores source port
// - exact source: 16-bit value must equal
// - source range: port between held bounds
// - destination don't-care ignores destination port
// - exact destination: 16-bit value must equal
// - destination range: port between held bounds
// - fin criterion: clear, set or ignore
// - syn criterion: clear, set or ignore
// - psh criterion: clear, set or ignore
// - ack criterion: clear, set or ignore
// - urg criterion: clear, set or ignore
module lpf_matcher
   import lpf_pkg::*;
#(
   parameter int NUM_ENTRIES = 4
)
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // axi4-lite write address
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // parsed header from the ingress parser
   input wire logic hdr_valid,
   input wire logic [7:0] hdr_ip_proto,
   input wire logic [PORT_W-1:0] hdr_src_port,
   input wire logic [PORT_W-1:0] hdr_dst_port,
   input wire logic [TFLAG_W-1:0] hdr_tcp_flags,
   // per-entry result to the action logic
   output logic match_valid,
   output logic [NUM_ENTRIES-1:0] match_hit
);
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
         input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // entry index of an address, valid only with entry_hit
   function automatic int entry_of(input logic [AXI_AW-1:0] a);
      logic [AXI_AW-1:0] off;
      off = a - ADDR_ENTRY_BASE;
      return int'(off >> ENTRY_STRIDE_SHIFT);
   endfunction

   function automatic logic entry_hit(input logic [AXI_AW-1:0] a);
      return (a >= ADDR_ENTRY_BASE) && (a[1:0] == 2'h0) &&
             (entry_of(a) < NUM_ENTRIES);
   endfunction

   function automatic logic [1:0] word_of(input logic [AXI_AW-1:0] a);
      return a[3:2];
   endfunction

   // ****************************************
   // entry storage
   // ****************************************
   logic [CTRL_W-1:0] ctrl_reg [NUM_ENTRIES];
   logic [FLAGS_W-1:0] flags_reg [NUM_ENTRIES];
   logic [31:0] src_reg [NUM_ENTRIES];
   logic [31:0] dst_reg [NUM_ENTRIES];
   logic [31:0] frames_reg;
   logic [NUM_ENTRIES-1:0] status_reg;

   // ****************************************
   // write channel
   // ****************************************
   logic aw_held_reg;
   logic w_held_reg;
   logic [AXI_AW-1:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;

   wire logic aw_take = s_axi_awvalid && awready_reg;
   wire logic w_take = s_axi_wvalid && wready_reg;
   wire logic do_write = aw_held_reg && w_held_reg && !bvalid_reg;
   wire logic b_done = bvalid_reg && s_axi_bready;
   wire logic waddr_entry = entry_hit(waddr_reg);
   wire logic waddr_ok = waddr_entry || (waddr_reg == ADDR_STATUS) ||
                         (waddr_reg == ADDR_FRAMES);
   wire logic bvalid_next = do_write || (bvalid_reg && !b_done);
   wire logic aw_held_next = aw_take || (aw_held_reg && !do_write);
   wire logic w_held_next = w_take || (w_held_reg && !do_write);
   wire logic awready_next = !aw_held_next && !bvalid_next;
   wire logic wready_next = !w_held_next && !bvalid_next;
   wire logic [31:0] wsel = 32'(entry_of(waddr_reg));
   wire logic [1:0] wword = word_of(waddr_reg);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         waddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end else begin
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         if (aw_take) begin
            waddr_reg <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            // status and counter are read-only but mapped: okay, ignored
            bresp_reg <= waddr_ok ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // a field value outside its encoding is stored as written and makes
   // its own test never pass, so a bad setting cannot widen the filter
   always_ff @(posedge clk) begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
         if (sys_rst) begin
            ctrl_reg[i] <= CTRL_RESET;
            flags_reg[i] <= FLAGS_RESET;
            src_reg[i] <= PORT_RESET;
            dst_reg[i] <= PORT_RESET;
         end else if (do_write && waddr_entry && wsel == i) begin
            unique case (wword)
               WORD_CTRL: ctrl_reg[i] <= CTRL_W'(merge_strb(
                  32'(ctrl_reg[i]), wdata_reg, wstrb_reg));
               WORD_FLAGS: flags_reg[i] <= FLAGS_W'(merge_strb(
                  32'(flags_reg[i]), wdata_reg, wstrb_reg));
               WORD_SRC: src_reg[i] <= merge_strb(src_reg[i], wdata_reg,
                  wstrb_reg);
               WORD_DST: dst_reg[i] <= merge_strb(dst_reg[i], wdata_reg,
                  wstrb_reg);
            endcase
         end
      end
   end

   // ****************************************
   // read channel
   // ****************************************
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   wire logic ar_take = s_axi_arvalid && arready_reg;
   wire logic r_done = rvalid_reg && s_axi_rready;
   wire logic rvalid_next = ar_take || (rvalid_reg && !r_done);
   wire logic raddr_entry = entry_hit(s_axi_araddr);
   wire logic [31:0] rsel = raddr_entry ? 32'(entry_of(s_axi_araddr)) :
      32'h00000000;
   wire logic [1:0] rword = word_of(s_axi_araddr);
   wire logic [31:0] entry_rdata =
      (rword == WORD_CTRL) ? 32'(ctrl_reg[rsel]) :
      (rword == WORD_FLAGS) ? 32'(flags_reg[rsel]) :
      (rword == WORD_SRC) ? src_reg[rsel] : dst_reg[rsel];
   wire logic rd_status = (s_axi_araddr == ADDR_STATUS);
   wire logic rd_frames = (s_axi_araddr == ADDR_FRAMES);
   wire logic raddr_ok = raddr_entry || rd_status || rd_frames;
   wire logic [31:0] rdata_next =
      raddr_entry ? entry_rdata :
      rd_status ? 32'(status_reg) :
      rd_frames ? frames_reg : 32'h00000000;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
      end else begin
         arready_reg <= !rvalid_next;
         rvalid_reg <= rvalid_next;
         if (ar_take) begin
            rdata_reg <= rdata_next;
            rresp_reg <= raddr_ok ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // ****************************************
   // matching
   // ****************************************
   wire logic is_tcp = (hdr_ip_proto == IPPROTO_TCP);
   wire logic is_udp = (hdr_ip_proto == IPPROTO_UDP);
   wire logic [NUM_FLAGS-1:0] frame_flags = {hdr_tcp_flags[TFLAG_URG],
      hdr_tcp_flags[TFLAG_ACK], hdr_tcp_flags[TFLAG_PSH],
      hdr_tcp_flags[TFLAG_SYN], hdr_tcp_flags[TFLAG_FIN]};
   logic [NUM_ENTRIES-1:0] hit_next;

   for (genvar g = 0; g < NUM_ENTRIES; g++) begin : g_entry
      wire logic en = ctrl_reg[g][CTRL_EN_BIT];
      wire logic [1:0] proto = ctrl_reg[g][CTRL_PROTO_LSB +: 2];
      wire logic [1:0] smode = ctrl_reg[g][CTRL_SRC_LSB +: 2];
      wire logic [1:0] dmode = ctrl_reg[g][CTRL_DST_LSB +: 2];
      logic src_ok;
      logic dst_ok;
      logic flag_ok;

      lpf_port_match u_src (
         .mode(smode),
         .low_val(src_reg[g][PORT_W-1:0]),
         .high_val(src_reg[g][BOUND_HI_LSB +: PORT_W]),
         .port(hdr_src_port),
         .hit(src_ok)
      );

      lpf_port_match u_dst (
         .mode(dmode),
         .low_val(dst_reg[g][PORT_W-1:0]),
         .high_val(dst_reg[g][BOUND_HI_LSB +: PORT_W]),
         .port(hdr_dst_port),
         .hit(dst_ok)
      );

      lpf_flag_match u_flags (
         .crit(flags_reg[g]),
         .flags(frame_flags),
         .hit(flag_ok)
      );

      // port and flag criteria are only looked at under the entry's own
      // protocol; an any-protocol entry carries no layer-4 test here
      wire logic tcp_ok = is_tcp && src_ok && dst_ok && flag_ok;
      wire logic udp_ok = is_udp && src_ok && dst_ok;
      assign hit_next[g] = en && ((proto == PROTO_ANY) ||
         (proto == PROTO_TCP && tcp_ok) ||
         (proto == PROTO_UDP && udp_ok));
   end

   // one cycle from header to result; the result holds until next header
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         match_valid <= 1'b0;
         match_hit <= '0;
         status_reg <= '0;
         frames_reg <= '0;
      end else begin
         match_valid <= hdr_valid;
         if (hdr_valid) begin
            match_hit <= hit_next;
            status_reg <= hit_next;
            frames_reg <= frames_reg + 32'h00000001;
         end
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
endmodule

// ---- bench/lpf_matcher_checker.sv ----
module lpf_matcher_checker
   import lpf_pkg::*;
#(
   parameter int NUM_ENTRIES = 4
)
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register bus
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // header and result
   input wire logic hdr_valid,
   input wire logic [7:0] hdr_ip_proto,
   input wire logic [PORT_W-1:0] hdr_src_port,
   input wire logic [PORT_W-1:0] hdr_dst_port,
   input wire logic [TFLAG_W-1:0] hdr_tcp_flags,
   input wire logic match_valid,
   input wire logic [NUM_ENTRIES-1:0] match_hit
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // result timing and bus answers
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   a_hdr_to_match: assert property (hdr_valid |=> match_valid)
      else $error("no result pulse after a header");
   a_no_stray_match: assert property (!hdr_valid |=> !match_valid)
      else $error("result pulse without a header");
   a_hit_holds: assert property (!hdr_valid |=> $stable(match_hit))
      else $error("hit vector moved without a header");
   a_b_after_write: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response late");
   a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_aw_reopens: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid ##[1:2] s_axi_awready)
      else $error("write channel did not reopen");
   a_r_after_read: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read data late");
   a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address open during read data");
endmodule

// ---- bench/lpf_hdr_src.sv ----
module lpf_hdr_src
   import lpf_pkg::*;
(
   // clock
   input wire logic clk,
   // parsed header
   output logic hdr_valid,
   output logic [7:0] hdr_ip_proto,
   output logic [PORT_W-1:0] hdr_src_port,
   output logic [PORT_W-1:0] hdr_dst_port,
   output logic [TFLAG_W-1:0] hdr_tcp_flags
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      hdr_valid = 1'h0;
      {hdr_ip_proto, hdr_src_port, hdr_dst_port} = 40'h5a_c3a5_3c5a;
      hdr_tcp_flags = 6'h2d;
   end
   // one header per call, callable back to back every cycle
   task automatic send(input logic [7:0] p, input logic [15:0] s, d,
      input logic [5:0] f);
      hdr_valid <= 1'h1;
      hdr_ip_proto <= p;
      hdr_src_port <= s;
      hdr_dst_port <= d;
      hdr_tcp_flags <= f;
      @(posedge clk);
   endtask
   // fields invert when idle so stale values cannot pass for real ones
   task automatic idle();
      hdr_valid <= 1'h0;
      hdr_ip_proto <= ~hdr_ip_proto;
      hdr_src_port <= ~hdr_src_port;
      hdr_dst_port <= ~hdr_dst_port;
      hdr_tcp_flags <= ~hdr_tcp_flags;
   endtask
endmodule

// ---- bench/testbench.sv ----
module testbench
   import lpf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, sys_rst, hdr_valid, match_valid;
   logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, match_hit;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] hdr_ip_proto;
   logic [15:0] hdr_src_port, hdr_dst_port;
   logic [5:0] hdr_tcp_flags;
   logic [3:0] exp_q[$];
   int mismatches, samples_checked, nframes, nmatch;
   localparam logic [7:0] PT = IPPROTO_TCP;
   localparam logic [7:0] PU = IPPROTO_UDP;

   lpf_matcher #(.NUM_ENTRIES(4)) lpf_matcher_inst (.*);
   lpf_hdr_src lpf_hdr_src_inst (.*);

   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   task automatic conclude();
      $display("mismatches=%0d samples_checked=%0d", mismatches,
         samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [11:0] ea(input int e, input logic [1:0] w);
      return ADDR_ENTRY_BASE + 12'(e << ENTRY_STRIDE_SHIFT) + 12'({w, 2'h0});
   endfunction
   // ****************************************
   // register bus master
   // ****************************************
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hf, input logic [1:0] er = RESP_OKAY);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 64; n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      if (n == 64) begin
         mismatches++;
         conclude();
      end
      chk("bresp", 32'(er), 32'(s_axi_bresp));
      s_axi_bready <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
      input logic [1:0] er = RESP_OKAY);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 64; n++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      if (n == 64) begin
         mismatches++;
         conclude();
      end
      chk("rdata", e, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
      s_axi_rready <= 1'h0;
      @(posedge clk);
   endtask
   task automatic fr(input logic [7:0] p, input logic [15:0] s, d,
      input logic [5:0] f, input logic [3:0] e);
      exp_q.push_back(e);
      nframes++;
      lpf_hdr_src_inst.send(p, s, d, f);
   endtask
   // results come one cycle late, so a queue lets headers run back to back
   always @(posedge clk) begin
      if (match_valid === 1'h1) begin
         nmatch++;
         chk("match_hit", 32'(exp_q.pop_front()), 32'(match_hit));
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      sys_rst = 1'h1;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_wdata, s_axi_wstrb} = '0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'h0;
      @(posedge clk);
      rd(ea(3, WORD_CTRL), 32'h0);
      rd(ea(3, WORD_FLAGS), 32'(FLAGS_RESET));
      rd(ea(3, WORD_SRC), PORT_RESET);
      rd(12'h800, 32'h0, RESP_SLVERR);
      wr(12'h804, 32'h1, 4'hf, RESP_SLVERR);
      wr(ea(3, WORD_DST), 32'haaaa5555, 4'h3);
      rd(ea(3, WORD_DST), 32'hffff5555);
      wr(ea(0, WORD_SRC), 32'h50);
      rd(ea(0, WORD_SRC), 32'h50);
      wr(ea(0, WORD_DST), 32'h07d003e8);
      wr(ea(0, WORD_FLAGS), 32'h54);
      wr(ea(0, WORD_CTRL), 32'h4b);
      wr(ea(1, WORD_DST), 32'h35);
      wr(ea(1, WORD_FLAGS), 32'h2a9);
      wr(ea(1, WORD_CTRL), 32'h25);
      wr(ea(2, WORD_SRC), 32'h00c80064);
      wr(ea(2, WORD_FLAGS), 32'h28a);
      wr(ea(2, WORD_CTRL), 32'h13);
      fr(PT, 16'h50, 16'h3e8, 6'h1a, 4'h1);
      fr(PT, 16'h50, 16'h7d0, 6'h1a, 4'h1);
      fr(PT, 16'h50, 16'h7d1, 6'h1a, 4'h0);
      fr(PT, 16'h50, 16'h3e7, 6'h1a, 4'h0);
      fr(PT, 16'h51, 16'h5dc, 6'h1a, 4'h0);
      fr(PT, 16'h50, 16'h5dc, 6'h1b, 4'h0);
      fr(PT, 16'h50, 16'h5dc, 6'h18, 4'h0);
      fr(PT, 16'h50, 16'h5dc, 6'h12, 4'h0);
      fr(PT, 16'h50, 16'h5dc, 6'h0a, 4'h0);
      fr(PT, 16'h50, 16'h5dc, 6'h3a, 4'h0);
      fr(PT, 16'h64, 16'h0, 6'h3f, 4'h0);
      fr(PT, 16'hc8, 16'hffff, 6'h37, 4'h4);
      fr(PT, 16'hc9, 16'h5, 6'h0, 4'h0);
      fr(PT, 16'h63, 16'h5, 6'h0, 4'h0);
      fr(PU, 16'h50, 16'h3e8, 6'h1a, 4'h0);
      fr(PU, 16'h7, 16'h35, 6'h0, 4'h2);
      fr(PU, 16'hffff, 16'h35, 6'h3f, 4'h2);
      fr(PU, 16'h7, 16'h36, 6'h0, 4'h0);
      fr(PT, 16'h7, 16'h35, 6'h0, 4'h0);
      fr(8'h01, 16'h50, 16'h3e8, 6'h1a, 4'h0);
      lpf_hdr_src_inst.idle();
      // any-protocol entry hits even a frame with no layer-4 header
      wr(ea(3, WORD_CTRL), 32'h1);
      fr(8'h01, 16'h50, 16'h3e8, 6'h1a, 4'h8);
      lpf_hdr_src_inst.idle();
      repeat (2) @(posedge clk);
      chk("result_count", 32'(nframes), 32'(nmatch));
      rd(ADDR_FRAMES, 32'(nframes));
      rd(ADDR_STATUS, 32'h8);
      // mid-run reset must bring entries and counter back
      sys_rst <= 1'h1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'h0;
      @(posedge clk);
      rd(ea(0, WORD_CTRL), 32'(CTRL_RESET));
      rd(ea(0, WORD_SRC), PORT_RESET);
      rd(ADDR_FRAMES, 32'h0);
      conclude();
   end
endmodule

bind lpf_matcher lpf_matcher_checker #(.NUM_ENTRIES(NUM_ENTRIES))
   lpf_matcher_checker_inst (.*);
